// [wdnmi_pkg.sv]
package wdnmi_pkg;

  // core clock and watchdog tick timing
  localparam int unsigned CLK_PERIOD_NS  = 25;
  localparam int unsigned TICK_PERIOD_NS = 3906250;  // one period of the 256 hz tap
  localparam int unsigned TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;

  // watchdog counter geometry
  localparam int unsigned WD_CNT_W = 10;

  // register port geometry
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 4;

  // register byte addresses
  localparam logic [15:0] WATCHDOG_CONTROL_ADDR = 16'hff07;
  localparam logic [15:0] WD_IRQ_STATUS_ADDR    = 16'hff10;
  localparam logic [15:0] WD_IRQ_MASK_ADDR      = 16'hff11;
  localparam logic [15:0] WD_COUNT_LOW_ADDR     = 16'hff12;
  localparam logic [15:0] WD_COUNT_MID_ADDR     = 16'hff13;
  localparam logic [15:0] WD_COUNT_HIGH_ADDR    = 16'hff14;

  // watchdog_control fields
  localparam int unsigned WD_COUNTER_CLEAR_BIT = 0;
  localparam int unsigned WD_COUNT_ENABLE_BIT  = 1;
  localparam logic        WD_COUNT_ENABLE_RST  = 1'b1;

  // interrupt status and mask fields
  localparam int unsigned IRQ_TIMEOUT_BIT = 0;
  localparam int unsigned IRQ_NMI_TAKEN_BIT = 1;
  localparam logic [3:0]  IRQ_STATUS_RST  = 4'h0;
  localparam logic [3:0]  IRQ_MASK_RST    = 4'h0;
  localparam logic [3:0]  IRQ_IMPL_MASK   = 4'h3;

  // fixed program memory vector of the watchdog nmi
  localparam logic [15:0] NMI_VECTOR = 16'h0100;

endpackage

// [wdnmi_wrap_counter.sv]
`timescale 1ns/1ps

// free counter with synchronous clear that wraps after LAST
module wdnmi_wrap_counter
  #(
    parameter int unsigned     WIDTH = 10,
    parameter logic [WIDTH-1:0] LAST  = '1
  )
  (
    input  wire logic             core_clk_i,
    input  wire logic             rst_i,
    input  wire logic             clear_i,
    input  wire logic             count_en_i,
    output logic      [WIDTH-1:0] value_o,
    output logic                  wrap_o
  );

  logic [WIDTH-1:0] value_q;

  // count; clear beats counting so a clear always restarts from zero
  always_ff @(posedge core_clk_i) begin
    if (rst_i || clear_i) begin
      value_q <= '0;
    end else if (count_en_i) begin
      if (value_q == LAST) begin
        value_q <= '0;
      end else begin
        value_q <= value_q + 1'b1;
      end
    end
  end

  // one-cycle strobe on the step from LAST back to zero
  assign wrap_o  = count_en_i && !clear_i && (value_q == LAST);
  assign value_o = value_q;

endmodule

// [wdnmi_watchdog.sv]
// What this block does
// RULE_01 - missed periodic clear raises an nmi, ignoring the cpu interrupt enable flag
// RULE_02 - nmi held off until both stack pointer halves written as a pair
// RULE_03 - accepted nmi branches to fixed program vector 0100h
// RULE_04 - control register at watchdog_control; upper two bits read zero, ignore writes
// RULE_05 - enable bit 1 is read/write, set to one by initial reset
// RULE_06 - enable one counts; enable zero stops counting and blocks the nmi
// RULE_07 - writing one to bit 0 clears counter, counting resumes at once
// RULE_08 - clear bit always reads back as zero
// RULE_09 - software clears the watchdog within three seconds while enabled
// RULE_10 - unused watchdog must be disabled by software before first timeout
// RULE_11 - counter advances on a 256 hz tap
// RULE_12 - 10-bit counter; nmi on overflow of its last stage
// RULE_13 - counting continues in halt; the nmi releases halt
// RULE_14 - one request per overflow, held until accepted, no repeat
`timescale 1ns/1ps

module wdnmi_watchdog
  import wdnmi_pkg::*;
  #(
    parameter int unsigned TICK_CYCLES_P = TICK_CYCLES,
    parameter int unsigned CNT_W         = WD_CNT_W
  )
  (
    input  wire logic              core_clk_i,
    input  wire logic              rst_i,
    // software register port
    input  wire logic [ADDR_W-1:0] reg_addr_i,
    input  wire logic [DATA_W-1:0] reg_wdata_i,
    input  wire logic              reg_wr_i,
    input  wire logic              reg_rd_i,
    output logic      [DATA_W-1:0] reg_rdata_o,
    // core cpu side
    output logic                   nmi_req_o,
    input  wire logic              nmi_ack_i,
    output logic      [15:0]       nmi_vector_o,
    input  wire logic              stack_pointer_low_half_wr_i,
    input  wire logic              stack_pointer_high_half_wr_i,
    input  wire logic              cpu_halted_i,
    output logic                   halt_release_o,
    // maskable summary interrupt
    output logic                   irq_o
  );

  localparam int unsigned PRE_W = (TICK_CYCLES_P > 1) ? $clog2(TICK_CYCLES_P) : 1;
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_CYCLES_P - 1);
  localparam logic [CNT_W-1:0] CNT_LAST = '1;

  // register state
  logic              wd_count_enable_q;
  logic [DATA_W-1:0] irq_status_q;
  logic [DATA_W-1:0] irq_mask_q;
  logic [DATA_W-1:0] rdata_q;

  // nmi state
  logic              nmi_pending_q;
  logic              sp_low_seen_q;
  logic              sp_high_seen_q;
  logic              halt_release_q;
  logic [15:0]       nmi_vector_q;

  // decoded accesses
  logic              ctrl_wr;
  logic              status_wr;
  logic              mask_wr;
  logic              wd_counter_clear;
  logic              sp_mask_state;
  logic              nmi_taken;

  // counter chain signals
  logic [PRE_W-1:0]  pre_value;
  logic              tick_256hz;
  logic [CNT_W-1:0]  wd_count;
  logic              wd_overflow;
  // zero-extended copy so the nibble reads stay legal for counter widths up to 12 bits
  logic [11:0]       count_ext;

  // write decode
  assign ctrl_wr   = reg_wr_i && (reg_addr_i == WATCHDOG_CONTROL_ADDR);
  assign status_wr = reg_wr_i && (reg_addr_i == WD_IRQ_STATUS_ADDR);
  assign mask_wr   = reg_wr_i && (reg_addr_i == WD_IRQ_MASK_ADDR);

  // RULE_07 clear on one
  // a zero written to the clear bit does nothing
  assign wd_counter_clear = ctrl_wr && reg_wdata_i[WD_COUNTER_CLEAR_BIT];

  // enable bit; upper bits of the write are dropped
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      // RULE_05 enabled from reset
      wd_count_enable_q <= WD_COUNT_ENABLE_RST;
    end else if (ctrl_wr) begin
      // RULE_05 enable read write
      wd_count_enable_q <= reg_wdata_i[WD_COUNT_ENABLE_BIT];
    end
  end

  // RULE_11 256 hz tap
  // prescaler derives the tap from the core clock; cleared with the counter
  // so a restart always gets a full tick period before the first step
  wdnmi_wrap_counter #(
    .WIDTH (PRE_W),
    .LAST  (PRE_LAST)
  ) u_prescaler (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .clear_i    (wd_counter_clear),
    // RULE_06 stop when disabled
    .count_en_i (wd_count_enable_q),
    .value_o    (pre_value),
    .wrap_o     (tick_256hz)
  );

  // RULE_12 ten bit counter
  // RULE_13 counts in halt
  // the halt input is never looked at here, so halt cannot stop the count
  wdnmi_wrap_counter #(
    .WIDTH (CNT_W),
    .LAST  (CNT_LAST)
  ) u_wd_counter (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    // RULE_07 restart immediately
    .clear_i    (wd_counter_clear),
    .count_en_i (tick_256hz),
    .value_o    (wd_count),
    .wrap_o     (wd_overflow)
  );

  // RULE_02 pair tracking
  // mask state holds until both halves are written; writing one half again
  // forgets the other, which covers a stack pointer reload in progress
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      sp_low_seen_q <= 1'b0;
    end else if (stack_pointer_low_half_wr_i) begin
      sp_low_seen_q <= 1'b1;
    end else if (stack_pointer_high_half_wr_i && sp_low_seen_q && sp_high_seen_q) begin
      sp_low_seen_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      sp_high_seen_q <= 1'b0;
    end else if (stack_pointer_high_half_wr_i) begin
      sp_high_seen_q <= 1'b1;
    end else if (stack_pointer_low_half_wr_i && sp_low_seen_q && sp_high_seen_q) begin
      sp_high_seen_q <= 1'b0;
    end
  end

  assign sp_mask_state = !(sp_low_seen_q && sp_high_seen_q);

  assign count_ext = 12'(wd_count);

  // RULE_02 hold off request
  // the request waits, it is not lost, while the cpu is in mask state
  assign nmi_req_o = nmi_pending_q && !sp_mask_state;
  assign nmi_taken = nmi_req_o && nmi_ack_i;

  // RULE_14 one per overflow
  // overflow while pending merges into the one request; set beats clear
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      nmi_pending_q <= 1'b0;
    // RULE_01 nmi on timeout
    // RULE_06 disabled blocks nmi
    end else if (wd_overflow && wd_count_enable_q) begin
      nmi_pending_q <= 1'b1;
    end else if (nmi_taken) begin
      nmi_pending_q <= 1'b0;
    end
  end

  // RULE_03 fixed vector
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      nmi_vector_q <= NMI_VECTOR;
    end else begin
      nmi_vector_q <= NMI_VECTOR;
    end
  end

  assign nmi_vector_o = nmi_vector_q;

  // RULE_13 release halt
  // registered so the halt logic sees a clean level while the nmi is offered
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      halt_release_q <= 1'b0;
    end else begin
      halt_release_q <= nmi_req_o && cpu_halted_i && !nmi_ack_i;
    end
  end

  assign halt_release_o = halt_release_q;

  // sticky event bits, write one to clear, a new event wins over the clear
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      irq_status_q <= IRQ_STATUS_RST;
    end else begin
      if (wd_overflow && wd_count_enable_q) begin
        irq_status_q[IRQ_TIMEOUT_BIT] <= 1'b1;
      end else if (status_wr && reg_wdata_i[IRQ_TIMEOUT_BIT]) begin
        irq_status_q[IRQ_TIMEOUT_BIT] <= 1'b0;
      end
      if (nmi_taken) begin
        irq_status_q[IRQ_NMI_TAKEN_BIT] <= 1'b1;
      end else if (status_wr && reg_wdata_i[IRQ_NMI_TAKEN_BIT]) begin
        irq_status_q[IRQ_NMI_TAKEN_BIT] <= 1'b0;
      end
    end
  end

  // mask register, only implemented bits stored
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      irq_mask_q <= IRQ_MASK_RST;
    end else if (mask_wr) begin
      irq_mask_q <= reg_wdata_i & IRQ_IMPL_MASK;
    end
  end

  // level interrupt while any enabled status bit is set
  assign irq_o = |(irq_status_q & irq_mask_q);

  // read data stand only in the cycle after the read strobe
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rdata_q <= '0;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        // RULE_04 upper bits zero
        // RULE_08 clear reads zero
        WATCHDOG_CONTROL_ADDR: begin
          rdata_q <= {2'b00, wd_count_enable_q, 1'b0};
        end
        WD_IRQ_STATUS_ADDR: begin
          rdata_q <= irq_status_q;
        end
        WD_IRQ_MASK_ADDR: begin
          rdata_q <= irq_mask_q;
        end
        WD_COUNT_LOW_ADDR: begin
          rdata_q <= count_ext[3:0];
        end
        WD_COUNT_MID_ADDR: begin
          rdata_q <= count_ext[7:4];
        end
        WD_COUNT_HIGH_ADDR: begin
          rdata_q <= count_ext[11:8];
        end
        default: begin
          rdata_q <= '0;  // unmapped addresses read zero
        end
      endcase
    end else begin
      rdata_q <= '0;
    end
  end

  assign reg_rdata_o = rdata_q;

  // RULE_09 software keeps clearing
  // RULE_10 software disables if unused
  // both are duties of the program; the block only offers the clear and
  // enable bits above. the prescaler value is not read out through any
  // register.

endmodule

// [wdnmi_checker.sv]
`timescale 1ns/1ps

// port-level checker; helper flops mirror the enable bit and the sp pair state
module wdnmi_checker
  import wdnmi_pkg::*;
  (
    input  wire logic              core_clk_i,
    input  wire logic              rst_i,
    input  wire logic [ADDR_W-1:0] reg_addr_i,
    input  wire logic [DATA_W-1:0] reg_wdata_i,
    input  wire logic              reg_wr_i,
    input  wire logic              reg_rd_i,
    input  wire logic [DATA_W-1:0] reg_rdata_o,
    input  wire logic              nmi_req_o,
    input  wire logic              nmi_ack_i,
    input  wire logic [15:0]       nmi_vector_o,
    input  wire logic              stack_pointer_low_half_wr_i,
    input  wire logic              stack_pointer_high_half_wr_i,
    input  wire logic              cpu_halted_i,
    input  wire logic              halt_release_o,
    input  wire logic              irq_o
  );
  logic en_q;
  logic lo_q;
  logic hi_q;
  wire  lo_w = stack_pointer_low_half_wr_i;
  wire  hi_w = stack_pointer_high_half_wr_i;
  wire  sp_w = lo_w | hi_w;
  // enable mirror, set by reset
  always_ff @(posedge core_clk_i) begin
    if (rst_i) en_q <= 1'b1;
    else if (reg_wr_i && reg_addr_i == WATCHDOG_CONTROL_ADDR) en_q <= reg_wdata_i[1];
  end
  // a lone half write after a full pair means reload, so the mask returns
  always_ff @(posedge core_clk_i) begin
    lo_q <= !rst_i && (lo_w || (lo_q && !(hi_w && hi_q)));
    hi_q <= !rst_i && (hi_w || (hi_q && !(lo_w && lo_q)));
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  vec_fixed_a: assert property (nmi_vector_o == NMI_VECTOR)
    else $error("nmi vector wrong");
  rd_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 4'h0)
    else $error("read data outside read slot");
  ctl_read_a: assert property ($past(reg_rd_i && reg_addr_i == WATCHDOG_CONTROL_ADDR)
    |-> reg_rdata_o == {2'b00, en_q, 1'b0}) else $error("control readback wrong");
  sp_mask_a: assert property (nmi_req_o |-> lo_q && hi_q)
    else $error("nmi shown during sp mask");
  req_hold_a: assert property (nmi_req_o && !nmi_ack_i && !sp_w |=> nmi_req_o)
    else $error("nmi dropped before accept");
  ack_drop_a: assert property (nmi_req_o && nmi_ack_i |=> !nmi_req_o)
    else $error("nmi repeated after accept");
  off_quiet_a: assert property (!en_q && !nmi_req_o && !sp_w |=> !nmi_req_o)
    else $error("nmi while disabled");
  halt_rel_a: assert property (nmi_req_o && cpu_halted_i && !nmi_ack_i |=> halt_release_o)
    else $error("halt not released");
endmodule

bind wdnmi_watchdog wdnmi_checker chk_u (.*);

// [wdnmi_cpu_model.sv]
`timescale 1ns/1ps

// cpu stand-in: writes the sp pair on command, accepts the nmi after a set delay
module wdnmi_cpu_model (
  input  wire logic        core_clk_i,
  input  wire logic        sp_go_i,
  input  wire logic [3:0]  ack_dly_i,
  input  wire logic        nmi_req_i,
  input  wire logic [15:0] vec_i,
  output logic             ack_o,
  output logic             sp_lo_o,
  output logic             sp_hi_o
);
  logic [3:0] wait_q;
  initial {ack_o, sp_lo_o, sp_hi_o, wait_q} = '0;
  // pair: low half then high half
  always @(posedge core_clk_i) begin
    sp_lo_o <= sp_go_i;
    sp_hi_o <= sp_lo_o;
  end
  // accepts regardless of any enable flag, only at the fixed vector
  always @(posedge core_clk_i) begin
    wait_q <= (nmi_req_i && !ack_o) ? wait_q + 4'h1 : 4'h0;
    ack_o  <= nmi_req_i && !ack_o && wait_q >= ack_dly_i && vec_i == 16'h0100;
  end
endmodule

// [tb_top.sv]
`timescale 1ns/1ps

module tb_top
  import wdnmi_pkg::*;
  ;
  // short tick and counter so a timeout is 32 cycles
  localparam int TMO = 2 * 16;
  typedef struct {logic [15:0] a; logic [3:0] d; logic [3:0] e;} wdnmi_row_type;
  wdnmi_row_type rows [6] = '{'{WATCHDOG_CONTROL_ADDR, 4'hf, 4'h2},
    '{WATCHDOG_CONTROL_ADDR, 4'hd, 4'h0}, '{WATCHDOG_CONTROL_ADDR, 4'he, 4'h2},
    '{WD_IRQ_MASK_ADDR, 4'hf, 4'h3}, '{WD_IRQ_MASK_ADDR, 4'h0, 4'h0}, '{16'hff00, 4'hf, 4'h0}};
  logic core_clk_i = 0, rst_i = 1, reg_wr_i = 0, reg_rd_i = 0, cpu_halted_i = 0, sp_go = 0;
  logic [15:0] reg_addr_i = '0, nmi_vector_o;
  logic [3:0] reg_wdata_i = '0, reg_rdata_o, ack_dly = '0, rd_v;
  logic nmi_req_o, nmi_ack_i, stack_pointer_low_half_wr_i, stack_pointer_high_half_wr_i;
  logic halt_release_o, irq_o;
  int fails = 0, num_checks = 0, n;
  always #12.5 core_clk_i = ~core_clk_i;
  wdnmi_watchdog #(.TICK_CYCLES_P(2), .CNT_W(4)) dut_u (.*);
  wdnmi_cpu_model cpu_u (.core_clk_i(core_clk_i), .sp_go_i(sp_go), .ack_dly_i(ack_dly),
    .nmi_req_i(nmi_req_o), .vec_i(nmi_vector_o), .ack_o(nmi_ack_i),
    .sp_lo_o(stack_pointer_low_half_wr_i), .sp_hi_o(stack_pointer_high_half_wr_i));
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [3:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  // data is taken just after the edge that opens its one-cycle slot
  task automatic rd(input logic [15:0] a, output logic [3:0] d);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
    @(posedge core_clk_i);
  endtask
  task automatic wait_req(input int lim, output int c);
    c = 0;
    while (nmi_req_o !== 1'b1 && c < lim) begin
      @(posedge core_clk_i);
      #1 c++;
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge core_clk_i);
    rst_i <= 1'b0;
    rd(WATCHDOG_CONTROL_ADDR, rd_v);
    chk("control after reset", 4'h2, rd_v);
    // register table rows: write then read back
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rd_v);
      chk("register readback", rows[i].e, rd_v);
    end
    // timeout hidden until the sp pair is written, halted cpu
    wr(WATCHDOG_CONTROL_ADDR, 4'h3);
    cpu_halted_i <= 1'b1;
    ack_dly <= 4'h2;
    repeat (TMO + 4) @(posedge core_clk_i);
    #1 chk("masked request", 1'b0, nmi_req_o);
    wr(WATCHDOG_CONTROL_ADDR, 4'h3);
    sp_go <= 1'b1;
    @(posedge core_clk_i);
    sp_go <= 1'b0;
    wait_req(6, n);
    chk("request after pair", 1'b1, nmi_req_o);
    chk("nmi vector", NMI_VECTOR, nmi_vector_o);
    @(posedge core_clk_i);
    #1 chk("halt release", 1'b1, halt_release_o);
    repeat (5) @(posedge core_clk_i);
    #1 chk("request after accept", 1'b0, nmi_req_o);
    rd(WD_IRQ_STATUS_ADDR, rd_v);
    chk("status after accept", 4'h3, rd_v);
    wr(WD_IRQ_MASK_ADDR, 4'h1);
    #1 chk("irq unmasked", 1'b1, irq_o);
    wr(WD_IRQ_STATUS_ADDR, 4'h3);
    #1 chk("irq after clear", 1'b0, irq_o);
    // timeout length from a clear
    ack_dly <= 4'h0;
    wr(WATCHDOG_CONTROL_ADDR, 4'h3);
    wait_req(TMO + 8, n);
    chk("timeout window", 1'b1, n >= TMO - 3 && n <= TMO + 2);
    // regular clears hold it off; a zero in the clear bit does not
    repeat (4) begin
      repeat (TMO / 2) @(posedge core_clk_i);
      wr(WATCHDOG_CONTROL_ADDR, 4'h3);
      #1 chk("cleared in time", 1'b0, nmi_req_o);
    end
    repeat (TMO - 8) @(posedge core_clk_i);
    wr(WATCHDOG_CONTROL_ADDR, 4'h2);
    wait_req(16, n);
    chk("zero clear ignored", 1'b1, nmi_req_o);
    // disabled: no count, no request
    repeat (4) @(posedge core_clk_i);
    wr(WATCHDOG_CONTROL_ADDR, 4'h0);
    repeat (2 * TMO) @(posedge core_clk_i);
    #1 chk("disabled quiet", 1'b0, nmi_req_o);
    summarize();
  end
endmodule
